// file: rtl/drive_cfg.svh
// bit positions, reset values and timing constants of the drive command word decoder
`ifndef DRIVE_CFG_SVH
`define DRIVE_CFG_SVH
`define CW_WIDTH 16
`define CW_BUS_WIDTH 32
`define CW_RESET 16'h0000
`define CW_B_ENABLE 0
`define CW_B_RUN_FORWARD_CMD 1
`define CW_B_JOG_FORWARD_CMD 2
`define CW_B_RUN_REVERSE_CMD 3
`define CW_B_DIR 4
`define CW_B_RUN 5
`define CW_B_LATCH 6
`define CW_B_FB_SEL 7
`define CW_B_REF_SEL 8
`define CW_B_JOG_REVERSE_CMD 9
`define CW_B_TRIP 12
`define CW_B_RESET 13
`define CW_B_WDOG 14
`define CW_USED_MASK 16'h73ff
`define TRIP_CODE_NONE 8'h00
`define TRIP_CODE_FORCED 8'h23
`define TRIP_CODE_WDOG 8'h1e
`define CLK_HZ 20000000
`define WDOG_TIMEOUT_MS 1000
`define MS_PER_S 1000
`endif

// file: rtl/drive_control_word_decoder.sv
// drive command word decoder: run, jog, trip and link watchdog sequencing
`timescale 1ns/1ps
`include "drive_cfg.svh"

module drive_control_word_decoder #(
	parameter int WDOG_CYCLES = `CLK_HZ / `MS_PER_S * `WDOG_TIMEOUT_MS,
	parameter int WDOG_CNT_W = 25
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic cw_wr,
	input wire logic [`CW_BUS_WIDTH-1:0] cw_wdata,
	output logic [`CW_BUS_WIDTH-1:0] cw_rdata,
	input wire logic external_hw_enable_input,
	input wire logic control_word_enable_setting,
	input wire drive_pkg::drive_cmd_t terminal_cmd,
	input wire logic drive_fault,
	input wire logic [7:0] drive_fault_code,
	output drive_pkg::drive_cmd_t drive_cmd,
	output logic direction_reverse,
	output logic seq_latch,
	output logic fieldbus_control_active,
	output logic reference_select_parameter,
	output drive_pkg::trip_info_t trip_info,
	output logic forced_trip_display,
	output logic watchdog_active,
	output logic watchdog_trip,
	output drive_pkg::drive_state_t drive_state
);
	import drive_pkg::*;

	// elaboration check: the counter must hold the whole timeout, reload included
	if (WDOG_CYCLES < 2 || WDOG_CYCLES >= (1 << WDOG_CNT_W)) begin : g_wdog_fit
		$error("WDOG_CYCLES does not fit the watchdog counter");
	end
	// a generate check, so a bad parameter stops elaboration rather than the run

	// a word bit test, used all over the decode
	function automatic logic cw_bit(input logic [`CW_WIDTH-1:0] w, input int pos);
		cw_bit = w[pos];
	endfunction : cw_bit

	logic [`CW_WIDTH-1:0] cw_r;
	logic [`CW_WIDTH-1:0] cw_prev_r;
	logic hw_en_s1_r;
	logic hw_en_s2_r;
	drive_cmd_t term_s1_r;
	drive_cmd_t term_s2_r;
	drive_cmd_t cmd_r;
	drive_cmd_t cmd_nxt;
	logic dir_r;
	logic seq_latch_r;
	logic fb_active_r;
	logic ref_sel_r;
	logic trip_r;
	logic trip_nxt;
	logic forced_r;
	logic [7:0] code_r;
	logic [7:0] code_nxt;
	logic wdog_on_r;
	logic wdog_trip_r;
	logic [WDOG_CNT_W-1:0] wdog_cnt_r;
	drive_state_t state_r;
	drive_state_t state_nxt;
	logic fb_sel;
	logic reset_edge;
	logic wdog_edge;
	logic wdog_expire;
	logic any_run;
	logic cause;

	// control word register; the reserved upper half is dropped and reads zero
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cw_r <= `CW_RESET;
		end else if (cw_wr) begin
			cw_r <= cw_wdata[`CW_WIDTH-1:0];
		end
	end

	// previous word, for the reset and watchdog edge detectors
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cw_prev_r <= `CW_RESET;
		end else begin
			cw_prev_r <= cw_r;
		end
	end

	assign cw_rdata = {{(`CW_BUS_WIDTH-`CW_WIDTH){1'b0}}, cw_r};

	// external_hw_enable_input and terminal_cmd: two flops before any logic looks at them
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hw_en_s1_r <= 1'b0;
			hw_en_s2_r <= 1'b0;
			term_s1_r <= '0;
			term_s2_r <= '0;
		end else begin
			hw_en_s1_r <= external_hw_enable_input;
			hw_en_s2_r <= hw_en_s1_r;
			term_s1_r <= terminal_cmd;
			term_s2_r <= term_s1_r;
		end
	end

	// edge and select decode; a steady reset level does nothing
	assign fb_sel = cw_bit(cw_r, `CW_B_FB_SEL) && control_word_enable_setting;
	assign reset_edge = cw_bit(cw_r, `CW_B_RESET) && !cw_bit(cw_prev_r, `CW_B_RESET);
	assign wdog_edge = cw_bit(cw_r, `CW_B_WDOG) && !cw_bit(cw_prev_r, `CW_B_WDOG)
		&& control_word_enable_setting;
	assign wdog_expire = wdog_on_r && (wdog_cnt_r == '0) && !wdog_edge;
	assign any_run = cw_bit(cw_r, `CW_B_RUN) || cw_bit(cw_r, `CW_B_RUN_FORWARD_CMD)
		|| cw_bit(cw_r, `CW_B_RUN_REVERSE_CMD);
	// forced trip is decoded outside the select gate, so it always acts
	assign cause = cw_bit(cw_r, `CW_B_TRIP) || wdog_expire || drive_fault;

	// command decode; bits 10, 11 and 15 are never looked at
	always_comb begin
		cmd_nxt = '0;
		if (fb_sel) begin
			cmd_nxt.enable = cw_bit(cw_r, `CW_B_ENABLE);
			// the run bit follows the direction bit, which alone starts nothing
			cmd_nxt.run_forward_cmd = cw_bit(cw_r, `CW_B_RUN_FORWARD_CMD)
				|| (cw_bit(cw_r, `CW_B_RUN) && !cw_bit(cw_r, `CW_B_DIR));
			cmd_nxt.run_reverse_cmd = cw_bit(cw_r, `CW_B_RUN_REVERSE_CMD)
				|| (cw_bit(cw_r, `CW_B_RUN) && cw_bit(cw_r, `CW_B_DIR));
			cmd_nxt.jog_forward_cmd = cw_bit(cw_r, `CW_B_JOG_FORWARD_CMD) && !any_run;
			cmd_nxt.jog_reverse_cmd = cw_bit(cw_r, `CW_B_JOG_REVERSE_CMD) && !any_run;
		end else begin
			cmd_nxt = term_s2_r; // terminal control
		end
		// no external_hw_enable_input or a live trip: everything off, motor coasts
		if (!hw_en_s2_r || trip_r || cause) begin
			cmd_nxt = '0;
		end
		// run and jog only mean something with enable set
		if (!cmd_nxt.enable) begin
			cmd_nxt = '0;
		end
	end

	// drive command outputs, registered
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_r <= '0;
		end else begin
			cmd_r <= cmd_nxt;
		end
	end

	// direction select and reference select follow their bits directly
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dir_r <= 1'b0;
			ref_sel_r <= 1'b0;
			fb_active_r <= 1'b0;
		end else begin
			dir_r <= cw_bit(cw_r, `CW_B_DIR);
			ref_sel_r <= cw_bit(cw_r, `CW_B_REF_SEL);
			fb_active_r <= fb_sel;
		end
	end

	// sequencing latch holds a run request; latch release low clears and holds it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			seq_latch_r <= 1'b0;
		end else if (!cw_bit(cw_r, `CW_B_LATCH)) begin
			seq_latch_r <= 1'b0;
		end else if (cmd_nxt.run_forward_cmd || cmd_nxt.run_reverse_cmd) begin
			seq_latch_r <= 1'b1;
		end else if (!cmd_nxt.enable) begin
			seq_latch_r <= 1'b0;
		end
	end

	// trip: a present cause wins over the reset edge, so it trips again at once
	always_comb begin
		trip_nxt = trip_r;
		code_nxt = code_r;
		if (reset_edge) begin
			trip_nxt = 1'b0;
			code_nxt = `TRIP_CODE_NONE;
		end
		if (cw_bit(cw_r, `CW_B_TRIP)) begin
			trip_nxt = 1'b1;
			code_nxt = `TRIP_CODE_FORCED;
		end else if (wdog_expire) begin
			trip_nxt = 1'b1;
			code_nxt = `TRIP_CODE_WDOG;
		end else if (drive_fault) begin
			trip_nxt = 1'b1;
			code_nxt = drive_fault_code;
		end
	end

	// the master is expected to check trip_info before re-running
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			trip_r <= 1'b0;
			code_r <= `TRIP_CODE_NONE;
			forced_r <= 1'b0;
		end else begin
			trip_r <= trip_nxt;
			code_r <= code_nxt;
			forced_r <= trip_nxt && (code_nxt == `TRIP_CODE_FORCED);
		end
	end

	// link watchdog: edge turns it on or reloads; expiry trips and turns it off
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wdog_on_r <= 1'b0;
			wdog_cnt_r <= '0;
			wdog_trip_r <= 1'b0;
		end else begin
			wdog_trip_r <= wdog_expire;
			if (wdog_edge) begin
				wdog_on_r <= 1'b1;
				wdog_cnt_r <= WDOG_CNT_W'(WDOG_CYCLES - 1);
			end else if (wdog_expire) begin
				wdog_on_r <= 1'b0;
			end else if (wdog_on_r) begin
				wdog_cnt_r <= wdog_cnt_r - 1'b1;
			end
		end
	end

	// sequencing state for the status side
	always_comb begin
		case (1'b1)
			trip_nxt: state_nxt = st_trip;
			(cmd_nxt.run_forward_cmd || cmd_nxt.run_reverse_cmd || cmd_nxt.jog_forward_cmd
				|| cmd_nxt.jog_reverse_cmd): state_nxt = st_run;
			cmd_nxt.enable: state_nxt = st_ready;
			default: state_nxt = st_idle;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= st_idle;
		end else begin
			case (state_nxt)
				st_idle, st_ready, st_run, st_trip: state_r <= state_nxt;
				default: state_r <= st_idle;
			endcase
		end
	end

	assign drive_cmd = cmd_r;
	assign direction_reverse = dir_r;
	assign seq_latch = seq_latch_r;
	assign fieldbus_control_active = fb_active_r;
	assign reference_select_parameter = ref_sel_r;
	assign trip_info = '{tripped: trip_r, forced: forced_r, code: code_r};
	assign forced_trip_display = forced_r;
	assign watchdog_active = wdog_on_r;
	assign watchdog_trip = wdog_trip_r;
	assign drive_state = state_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence rst_rise_s;
		!cw_r[`CW_B_RESET] ##1 cw_r[`CW_B_RESET];
	endsequence

	sequence quiet_s;
		!cw_r[`CW_B_TRIP] && !drive_fault && !wdog_on_r;
	endsequence

	hw_enable_gate_a: assert property (
		drive_cmd.enable |-> $past(hw_en_s2_r) && ($past(cw_r[`CW_B_ENABLE]) || !fb_active_r))
		else $error("drive enabled without external_hw_enable_input");

	coast_stop_a: assert property (
		fb_sel && !cw_r[`CW_B_ENABLE] |=> drive_cmd == '0)
		else $error("drive still enabled after enable bit cleared");

	forced_trip_a: assert property (
		cw_r[`CW_B_TRIP] |=> trip_info.tripped && trip_info.code == `TRIP_CODE_FORCED)
		else $error("forced trip not raised with its code");

	trip_hold_a: assert property (
		cw_r[`CW_B_TRIP] [*2] |=> trip_info.tripped)
		else $error("forced trip cleared while its bit is set");

	reset_clear_a: assert property (
		rst_rise_s ##0 quiet_s ##0 trip_r |=> !trip_info.tripped)
		else $error("reset edge did not clear trip");

	level_reset_a: assert property (
		trip_r && cw_r[`CW_B_RESET] && cw_prev_r[`CW_B_RESET] |=> trip_info.tripped)
		else $error("steady reset level cleared a trip");

	jog_yield_a: assert property (
		(drive_cmd.jog_forward_cmd || drive_cmd.jog_reverse_cmd) |-> !drive_cmd.run_forward_cmd && !drive_cmd.run_reverse_cmd)
		else $error("jog active beside a run command");

	ref_follow_a: assert property (
		##1 reference_select_parameter == $past(cw_r[`CW_B_REF_SEL]))
		else $error("reference select does not follow its bit");

	latch_clear_a: assert property (
		!cw_r[`CW_B_LATCH] |=> !seq_latch)
		else $error("sequencing latch not cleared");

	wdog_off_a: assert property (
		wdog_expire |=> !watchdog_active && watchdog_trip && trip_info.tripped)
		else $error("watchdog not off after its trip");

	wdog_on_a: assert property (
		wdog_edge |=> watchdog_active && wdog_cnt_r == WDOG_CNT_W'(WDOG_CYCLES - 1))
		else $error("watchdog edge did not arm watchdog");
endmodule : drive_control_word_decoder

// file: rtl/drive_pkg.sv
// types shared by the drive command word decoder
package drive_pkg;
	// one set of sequencing commands toward the drive
	typedef struct packed {
		logic enable;
		logic run_forward_cmd;
		logic run_reverse_cmd;
		logic jog_forward_cmd;
		logic jog_reverse_cmd;
	} drive_cmd_t;

	// trip state seen by the status side
	typedef struct packed {
		logic tripped;
		logic forced;
		logic [7:0] code;
	} trip_info_t;

	// drive sequencing state, gray coded along idle-ready-run-trip
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_ready = 2'b01,
		st_run = 2'b11,
		st_trip = 2'b10
	} drive_state_t;
endpackage : drive_pkg

// file: testbench/fieldbus_master_model.sv
// fieldbus master model that writes the drive command word
`timescale 1ns/1ps
module fieldbus_master_model (
	input wire logic clk,
	output logic cw_wr,
	output logic [31:0] cw_wdata
);
	initial begin
		cw_wr = 1'b0;
		cw_wdata = 32'h0;
	end
	// one write per call; data is inverted once released so a stale word never looks valid
	task automatic write_word(input logic [31:0] w);
		@(negedge clk);
		cw_wr = 1'b1;
		cw_wdata = w;
		@(negedge clk);
		cw_wr = 1'b0;
		cw_wdata = ~w;
	endtask : write_word
endmodule : fieldbus_master_model

// file: testbench/test_drive_control_word_decoder.sv
// self-checking testbench of the drive command word decoder
`timescale 1ns/1ps
module test_drive_control_word_decoder;
	import drive_pkg::*;
	localparam int WDOG = 50;
	logic clk, arst_n, cw_wr, hw_en, cw_en_set, fault;
	logic [31:0] cw_wdata, cw_rdata;
	logic [7:0] fault_code;
	drive_cmd_t term_cmd, cmd;
	trip_info_t trip;
	drive_state_t state;
	logic dir_rev, latch, fb_act, ref_sel, forced_disp, wd_act, wd_trip;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	int i;
	// decode table: word and expected {enable,run_forward_cmd,run_reverse_cmd,jog_forward_cmd,jog_reverse_cmd,direction}
	logic [31:0] tw [10] = '{32'h81, 32'h83, 32'h89, 32'hb1, 32'h85, 32'h281, 32'h287,
		32'h90, 32'ha0, 32'hffff8da1};
	logic [5:0] te [10] = '{6'h20, 6'h30, 6'h28, 6'h29, 6'h24, 6'h22, 6'h30, 6'h01, 6'h00, 6'h30};

	fieldbus_master_model master (.clk(clk), .cw_wr(cw_wr), .cw_wdata(cw_wdata));
	drive_control_word_decoder #(.WDOG_CYCLES(WDOG)) DUT (
		.clk(clk),
		.arst_n(arst_n),
		.cw_wr(cw_wr),
		.cw_wdata(cw_wdata),
		.cw_rdata(cw_rdata),
		.external_hw_enable_input(hw_en),
		.control_word_enable_setting(cw_en_set),
		.terminal_cmd(term_cmd),
		.drive_fault(fault),
		.drive_fault_code(fault_code),
		.drive_cmd(cmd),
		.direction_reverse(dir_rev),
		.seq_latch(latch),
		.fieldbus_control_active(fb_act),
		.reference_select_parameter(ref_sel),
		.trip_info(trip),
		.forced_trip_display(forced_disp),
		.watchdog_active(wd_act),
		.watchdog_trip(wd_trip),
		.drive_state(state)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// write, then let synchronisers and registered outputs settle
	task automatic wr(input logic [31:0] w);
		master.write_word(w);
		repeat (4) @(negedge clk);
	endtask : wr

	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim

	// hang guard, well above the few hundred cycles the sequence needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			$display("CHECK FAILED at %0t: run timed out", $time);
			end_sim();
		end
	end

	initial begin
		arst_n = 1'b0;
		hw_en = 1'b0;
		cw_en_set = 1'b0;
		fault = 1'b0;
		fault_code = 8'h55;
		term_cmd = '0;
		repeat (5) @(negedge clk);
		arst_n = 1'b1;
		chk(cw_rdata, 32'h0, "readback");
		chk({15'h0, cmd, trip, state}, 32'h0, "reset outputs");
		$display("test reset done");
		hw_en = 1'b1;
		cw_en_set = 1'b1;
		repeat (3) @(negedge clk);
		wr(32'ha1);
		chk({24'h0, cmd, fb_act, state}, {24'h0, 5'h18, 1'b1, st_run}, "run");
		for (i = 0; i < 10; i++) begin
			wr(tw[i]);
			chk({26'h0, cmd, dir_rev}, {26'h0, te[i]}, "decode");
			chk(cw_rdata, {16'h0, tw[i][15:0]}, "word");
			chk({31'h0, ref_sel}, {31'h0, tw[i][8]}, "reference");
		end
		$display("test decode done");
		wr(32'he1);
		chk({31'h0, latch}, 32'h1, "latch set");
		wr(32'ha1);
		chk({31'h0, latch}, 32'h0, "latch held clear");
		hw_en = 1'b0;
		wr(32'ha1);
		chk({31'h0, cmd.enable}, 32'h0, "hw enable gate");
		hw_en = 1'b1;
		term_cmd = 5'h14;
		wr(32'h21);
		chk({26'h0, fb_act, cmd}, {26'h0, 1'b0, 5'h14}, "terminal");
		cw_en_set = 1'b0;
		wr(32'ha1);
		chk({31'h0, fb_act}, 32'h0, "enable setting");
		cw_en_set = 1'b1;
		term_cmd = '0;
		$display("test control source done");
		wr(32'h1000);
		chk({19'h0, trip, forced_disp, state}, {19'h0, 10'h323, 1'b1, st_trip}, "forced trip");
		wr(32'h3000);
		chk({31'h0, trip.tripped}, 32'h1, "trip held");
		wr(32'h0);
		wr(32'h2000);
		chk({22'h0, trip}, 32'h0, "reset edge");
		fault = 1'b1;
		repeat (3) @(negedge clk);
		chk({22'h0, trip}, 32'h255, "fault trip");
		wr(32'h0);
		wr(32'h2000);
		chk({31'h0, trip.tripped}, 32'h1, "retrip");
		fault = 1'b0;
		wr(32'h2000);
		chk({31'h0, trip.tripped}, 32'h1, "steady level");
		wr(32'h0);
		wr(32'h2000);
		chk({22'h0, trip}, 32'h0, "cleared");
		$display("test trip done");
		wr(32'h4000);
		chk({31'h0, wd_act}, 32'h1, "watchdog on");
		// service well inside the shortened timeout
		for (i = 0; i < 4; i++) begin
			wr(32'h0);
			wr(32'h4000);
		end
		chk({30'h0, wd_act, trip.tripped}, 32'h2, "serviced");
		i = 0;
		while (wd_trip !== 1'b1 && i < 100) begin
			@(negedge clk);
			i++;
		end
		chk({31'h0, wd_trip}, 32'h1, "expiry");
		@(negedge clk);
		chk({21'h0, trip, wd_act}, {21'h0, 10'h21e, 1'b0}, "watchdog trip");
		wr(32'h0);
		wr(32'h2000);
		chk({21'h0, trip, wd_act}, 32'h0, "stays off");
		wr(32'h4000);
		chk({31'h0, wd_act}, 32'h1, "re-armed");
		$display("test watchdog done");
		end_sim();
	end
endmodule : test_drive_control_word_decoder
